// ### core/obpv_ctrl.sv
// programmer that writes and verifies a 32K x 8 one-time memory
// assumes power stage follows supply requests; memory data via data_wr_i
`timescale 1ns/10ps
`default_nettype none
`include "obpv_defs.svh"
module obpv_ctrl
  import obpv_pkg::*;
#(
  parameter int PW_CYC    = `OBPV_PW_CYC,    // program pulse in cycles
  parameter int SETUP_CYC = `OBPV_SETUP_CYC, // setup gap in cycles
  parameter int LAST_ADDR = `OBPV_LAST_ADDR  // last address programmed
) (
  input  wire  logic                    ref_clk_i,   // 25 MHz clock
  input  wire  logic                    rst_i,       // sync reset, high
  input  wire  logic                    start_i,     // begin programming
  input  wire  logic                    id_req_i,    // read id codes
  input  wire  logic [7:0]              data_wr_i,   // image byte at addr
  input  wire  logic [7:0]              data_pins_i, // memory data pins in
  output logic [`OBPV_ADDR_W-1:0]       addr_o,      // memory address
  output logic [7:0]                    data_pins_o, // memory data pins out
  output logic                          data_pins_oe_o, // drive data pins
  output logic                          ce_n_o,      // program strobe, low
  output logic                          oe_n_o,      // output gate, low
  output obpv_sup_t                     vcc_lvl_o,   // logic supply level
  output obpv_sup_t                     vpp_lvl_o,   // program supply level
  output logic                          id_mode_address_line_o, // raise line 9
  output logic                          busy_o,      // sequence running
  output logic                          done_o,      // sequence finished
  output logic                          fail_o,      // device failed
  output logic [7:0]                    maker_code_o,  // id byte, bit low
  output logic [7:0]                    device_code_o  // id byte, bit high
);
  // refuse parameters the counters cannot hold
  if (PW_CYC < 2 || SETUP_CYC < 1 || LAST_ADDR < 0 ||
      LAST_ADDR > (1 << `OBPV_ADDR_W) - 1 ||
      2*SETUP_CYC + PW_CYC > 65535) begin : g_bad_param
    $error("obpv_ctrl: bad parameter");
  end

  obpv_state_t           state_reg;   // sequencer state
  logic [15:0]           tmr_reg;     // phase timer
  logic [3:0]            retry_reg;   // retry pulses applied
  logic                  id_sel_reg;  // which id byte is read

  // true at last address
  function automatic logic at_last(input logic [`OBPV_ADDR_W-1:0] a);
    at_last = (a == LAST_ADDR[`OBPV_ADDR_W-1:0]);
  endfunction

  // timer phases: setup gap, pulse, then gap
  wire logic t_pulse = (tmr_reg >= 16'(SETUP_CYC)) &&
                       (tmr_reg < 16'(SETUP_CYC + PW_CYC));
  wire logic t_end   = (tmr_reg == 16'(2*SETUP_CYC + PW_CYC));
  wire logic t_rd    = (tmr_reg == 16'(SETUP_CYC + `OBPV_OE_CYC));
  wire logic match   = (data_pins_i == data_wr_i);

  // state sequencing and counters
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg  <= OBPV_IDLE;
      tmr_reg    <= 16'h0000;
      retry_reg  <= 4'h0;
      addr_o     <= '0;
      fail_o     <= 1'b0;
      done_o     <= 1'b0;
      id_sel_reg <= 1'b0;
      maker_code_o  <= 8'h00;
      device_code_o <= 8'h00;
    end else begin
      tmr_reg <= tmr_reg + 16'h0001;
      case (state_reg)
        OBPV_IDLE: begin
          tmr_reg <= 16'h0000;
          if (start_i) begin
            addr_o    <= '0;
            fail_o    <= 1'b0;
            done_o    <= 1'b0;
            state_reg <= OBPV_PWR_UP;
          end else if (id_req_i) begin
            addr_o     <= '0;
            id_sel_reg <= 1'b0;
            done_o     <= 1'b0;
            state_reg  <= OBPV_IDREAD;
          end
        end
        OBPV_PWR_UP: begin                        // supplies settle
          if (tmr_reg == 16'(2*SETUP_CYC)) begin
            tmr_reg   <= 16'h0000;
            state_reg <= OBPV_PASS1;
          end
        end
        OBPV_PASS1: begin
          if (t_end) begin
            tmr_reg <= 16'h0000;
            if (at_last(addr_o)) begin
              addr_o    <= '0;
              state_reg <= OBPV_VREAD;
            end else begin
              addr_o <= addr_o + 1'b1;
            end
          end
        end
        OBPV_VREAD: begin
          if (t_rd) begin
            tmr_reg <= 16'h0000;
            if (match) begin
              retry_reg <= 4'h0;
              if (at_last(addr_o)) begin
                state_reg <= OBPV_PWR_DN;
              end else begin
                addr_o <= addr_o + 1'b1;
              end
            end else if (retry_reg == 4'(`OBPV_MAX_RETRY)) begin
              fail_o    <= 1'b1;
              state_reg <= OBPV_PWR_DN;
            end else begin
              state_reg <= OBPV_RETRY;
            end
          end
        end
        OBPV_RETRY: begin
          if (t_end) begin
            tmr_reg   <= 16'h0000;
            retry_reg <= retry_reg + 4'h1;
            state_reg <= OBPV_VREAD;
          end
        end
        OBPV_PWR_DN: begin
          if (tmr_reg == 16'(2*SETUP_CYC)) begin
            tmr_reg   <= 16'h0000;
            addr_o    <= '0;
            state_reg <= fail_o ? OBPV_DONE : OBPV_FREAD;
          end
        end
        OBPV_FREAD: begin
          if (t_rd) begin
            tmr_reg <= 16'h0000;
            if (!match) begin
              fail_o    <= 1'b1;
              state_reg <= OBPV_DONE;
            end else if (at_last(addr_o)) begin
              state_reg <= OBPV_DONE;
            end else begin
              addr_o <= addr_o + 1'b1;
            end
          end
        end
        OBPV_IDREAD: begin
          if (t_rd) begin
            tmr_reg <= 16'h0000;
            if (!id_sel_reg) begin
              maker_code_o <= data_pins_i;
              id_sel_reg   <= 1'b1;
              addr_o       <= 15'h0001;            // select device byte
            end else begin
              device_code_o <= data_pins_i;
              state_reg     <= OBPV_DONE;
            end
          end
        end
        OBPV_DONE: begin
          done_o    <= 1'b1;
          retry_reg <= 4'h0;
          state_reg <= OBPV_IDLE;
        end
        default: state_reg <= OBPV_IDLE;
      endcase
    end
  end

  // pin drive: strobe, gate and data direction
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ce_n_o         <= 1'b1;
      oe_n_o         <= 1'b1;
      data_pins_o    <= 8'h00;
      data_pins_oe_o <= 1'b0;
      id_mode_address_line_o <= 1'b0;
    end else begin
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      data_pins_oe_o <= 1'b0;
      id_mode_address_line_o <= (state_reg == OBPV_IDREAD);
      case (state_reg)
        OBPV_PASS1, OBPV_RETRY: begin
          data_pins_o    <= data_wr_i;
          data_pins_oe_o <= !t_end;
          ce_n_o         <= !t_pulse;
        end
        OBPV_VREAD, OBPV_FREAD, OBPV_IDREAD: begin
          // strobe only together with the gate: strobe low, gate off and
          // raised program supply would program whatever floats on pins
          ce_n_o <= (tmr_reg < 16'(SETUP_CYC - 1));
          oe_n_o <= (tmr_reg < 16'(SETUP_CYC - 1));
        end
        default: data_pins_o <= data_pins_o;
      endcase
    end
  end

  // supply requests and status
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      vcc_lvl_o <= OBPV_SUP_OFF;
      vpp_lvl_o <= OBPV_SUP_OFF;
      busy_o    <= 1'b0;
    end else begin
      busy_o <= (state_reg != OBPV_IDLE) && (state_reg != OBPV_DONE);
      case (state_reg)
        OBPV_PWR_UP: begin
          vcc_lvl_o <= OBPV_SUP_PROG;
          if (tmr_reg >= 16'(SETUP_CYC))
            vpp_lvl_o <= OBPV_SUP_PROG;
        end
        OBPV_PWR_DN: begin
          vpp_lvl_o <= OBPV_SUP_READ;
          if (tmr_reg >= 16'(SETUP_CYC))
            vcc_lvl_o <= OBPV_SUP_READ;
        end
        OBPV_IDREAD: begin
          vcc_lvl_o <= OBPV_SUP_READ;
          vpp_lvl_o <= OBPV_SUP_READ;
        end
        OBPV_IDLE: begin
          vpp_lvl_o <= OBPV_SUP_READ;
          vcc_lvl_o <= OBPV_SUP_READ;
        end
        default: vcc_lvl_o <= vcc_lvl_o;
      endcase
    end
  end

  // pulse width, pin sharing, supply order, retry and address checks
  int pw_cnt;
  always_ff @(posedge ref_clk_i)
    pw_cnt <= (rst_i || ce_n_o) ? 0 : pw_cnt + 1;
  a_pulse_width: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(ce_n_o) && $past(data_pins_oe_o)
    |-> $past(pw_cnt) == PW_CYC - 1)
    else $error("program pulse width wrong");
  a_data_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    data_pins_oe_o |-> oe_n_o)
    else $error("data driven with gate low");
  a_strobe_data: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !ce_n_o && oe_n_o |-> data_pins_oe_o)
    else $error("strobe low with data released");
  a_vpp_order: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    vpp_lvl_o == OBPV_SUP_PROG |-> vcc_lvl_o == OBPV_SUP_PROG)
    else $error("program supply ahead of logic");
  a_retry_limit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    retry_reg <= 4'(`OBPV_MAX_RETRY))
    else $error("too many retries");
  a_fail_stop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == OBPV_VREAD && t_rd && !match &&
    retry_reg == 4'(`OBPV_MAX_RETRY)
    |=> fail_o && state_reg == OBPV_PWR_DN)
    else $error("fail not reported");
  a_first_addr: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == OBPV_IDLE && start_i |=> addr_o == '0)
    else $error("not at first address");
  a_advance: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == OBPV_VREAD && t_rd && match && !at_last(addr_o)
    |=> addr_o == $past(addr_o) + 1'b1)
    else $error("address not advanced");
  a_low_supply: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == OBPV_FREAD |-> vpp_lvl_o == OBPV_SUP_READ)
    else $error("final read at high supply");
  c_retry: cover property (@(posedge ref_clk_i) state_reg == OBPV_RETRY);
  c_fail:  cover property (@(posedge ref_clk_i) $rose(fail_o));
  c_pass:  cover property (@(posedge ref_clk_i) done_o && !fail_o);
  c_id:    cover property (@(posedge ref_clk_i) state_reg == OBPV_IDREAD);
endmodule : obpv_ctrl
`default_nettype wire

// ### core/obpv_defs.svh
// constants for the one-time-programmable byte programmer controller
// assumes a 25 MHz reference clock; included by the package and the controller
`ifndef OBPV_DEFS_SVH
`define OBPV_DEFS_SVH
`define OBPV_CLK_MHZ      25
`define OBPV_PW_NS        100000
`define OBPV_PW_CYC       ((`OBPV_PW_NS * `OBPV_CLK_MHZ) / 1000)
`define OBPV_SETUP_NS     2000
`define OBPV_SETUP_CYC    ((`OBPV_SETUP_NS * `OBPV_CLK_MHZ + 999) / 1000)
`define OBPV_OE_NS        150
`define OBPV_OE_CYC       ((`OBPV_OE_NS * `OBPV_CLK_MHZ + 999) / 1000)
`define OBPV_MAX_RETRY    10
`define OBPV_ADDR_W       15
`define OBPV_LAST_ADDR    15'h7FFF
`endif

// ### core/obpv_pkg.sv
// types for the one-time-programmable byte programmer controller
// assumes obpv_defs.svh is on the include path
`default_nettype none
`include "obpv_defs.svh"
package obpv_pkg;
  // sequencer states
  typedef enum logic [3:0] {
    OBPV_IDLE   = 4'h0,
    OBPV_PWR_UP = 4'h1,
    OBPV_PASS1  = 4'h2,
    OBPV_VSETUP = 4'h3,
    OBPV_VREAD  = 4'h4,
    OBPV_RETRY  = 4'h5,
    OBPV_PWR_DN = 4'h6,
    OBPV_FREAD  = 4'h7,
    OBPV_DONE   = 4'h8,
    OBPV_IDREAD = 4'h9
  } obpv_state_t;
  // supply levels requested from the power stage
  typedef enum logic [1:0] {
    OBPV_SUP_OFF  = 2'h0,
    OBPV_SUP_READ = 2'h1,
    OBPV_SUP_PROG = 2'h2
  } obpv_sup_t;
endpackage : obpv_pkg
`default_nettype wire

// ### dv/obpv_otp_model.sv
// behavioural one-time memory standing on the programmer's far side
// assumes supply levels arrive as obpv_sup_t codes, four cells used
`timescale 1ns/10ps
`default_nettype none
module obpv_otp_model
  import obpv_pkg::*;
#(
  parameter logic [7:0] MAKER_ID  = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'hA5, // arbitrary value
  parameter int         PW_NS     = 400    // nominal pulse length
) (
  input  wire logic [14:0] addr_i,      // address lines
  input  wire logic [7:0]  data_i,      // data pins as seen
  input  wire logic        ce_n_i,      // program strobe, low
  input  wire logic        oe_n_i,      // output gate, low
  input  wire obpv_sup_t   vpp_i,       // program supply
  input  wire logic        id_line_i,   // raised line nine
  input  wire logic        blank_i,     // fit a fresh part
  input  wire logic [1:0]  weak_addr_i, // slow cell
  input  wire logic [7:0]  weak_need_i, // pulses it needs
  output logic [7:0]       q_o,         // data driven out
  output logic             q_en_o       // driving the pins
);
  logic [7:0] mem [4];  // cell contents
  int         hits [4]; // long pulses seen per cell
  time        t_fall;   // start of the strobe
  // a fresh part reads all ones
  always @(posedge blank_i) foreach (mem[i]) begin
    mem[i] = 8'hFF;
    hits[i] = 0;
  end
  always @(negedge ce_n_i) t_fall = $time;
  // a pulse only counts at program supply, gate off, long enough
  always @(posedge ce_n_i) if (vpp_i == OBPV_SUP_PROG && oe_n_i &&
      ($time - t_fall) >= PW_NS * 95 / 100) begin
    hits[addr_i[1:0]]++;
    if (hits[addr_i[1:0]] >= ((addr_i[1:0] == weak_addr_i) ?
        int'(weak_need_i) : 1))
      mem[addr_i[1:0]] = mem[addr_i[1:0]] & data_i;
  end
  // id codes picked by the lowest address bit
  assign q_o = id_line_i ? (addr_i[0] ? DEVICE_ID : MAKER_ID)
                         : mem[addr_i[1:0]];
  assign q_en_o = !ce_n_i && !oe_n_i;
endmodule : obpv_otp_model
`default_nettype wire

// ### dv/otp_byte_program_verify_tb_top.sv
// self-checking bench for the programmer against a memory model
// assumes reduced counts: four bytes, setup 4, pulse 10 cycles
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin \
  bad_count++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module otp_byte_program_verify_tb_top;
  import obpv_pkg::*;
  localparam int PW = 10;       // reduced pulse length
  localparam int RETRIES = 10;  // retry pulses allowed per byte
  logic clk = 0, rst = 1, start = 0, id = 0, blank = 0;
  logic [1:0] weak_addr = 0;    // slow cell
  logic [7:0] weak_need = 1;    // pulses it needs
  logic [7:0] img [4];          // image written
  logic [7:0] pins, last = 0, d_o, q; // data pin levels
  logic [14:0] addr;
  logic d_oe, q_en, ce_n, oe_n, idl, busy, done, fail;
  logic [7:0] mk, dv;
  obpv_sup_t vcc, vpp;
  int bad_count = 0, total_checks = 0, seed = 71, lowcnt = 0;
  int pulses [4];
  bit first, saw_prog;
  always #20 clk = ~clk;
  // released pins show the inverse of their last level
  assign pins = d_oe ? d_o : (q_en ? q : ~last);
  always @(posedge clk) last <= pins;
  obpv_ctrl #(.PW_CYC(PW), .SETUP_CYC(4), .LAST_ADDR(3)) DUT (
    .ref_clk_i(clk), .rst_i(rst), .start_i(start), .id_req_i(id),
    .data_wr_i(img[addr[1:0]]), .data_pins_i(pins), .addr_o(addr),
    .data_pins_o(d_o), .data_pins_oe_o(d_oe), .ce_n_o(ce_n),
    .oe_n_o(oe_n), .vcc_lvl_o(vcc), .vpp_lvl_o(vpp),
    .id_mode_address_line_o(idl), .busy_o(busy), .done_o(done),
    .fail_o(fail), .maker_code_o(mk), .device_code_o(dv));
  obpv_otp_model #(.PW_NS(PW * 40)) M (
    .addr_i(addr), .data_i(pins), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .vpp_i(vpp), .id_line_i(idl), .blank_i(blank),
    .weak_addr_i(weak_addr), .weak_need_i(weak_need), .q_o(q),
    .q_en_o(q_en));
  // watch pulse lengths, supply order and pin sharing
  always @(posedge clk) if (!rst) begin
    if (!ce_n && d_oe) begin
      lowcnt <= lowcnt + 1;
      `CHK("gate_off", 1'b1, oe_n)
    end else if (lowcnt != 0) begin
      `CHK("pulse_len", PW, lowcnt)
      if (first) `CHK("first_addr", 15'h0, addr)
      first = 0;
      pulses[addr[1:0]]++;
      lowcnt <= 0;
    end
    if (vpp == OBPV_SUP_PROG) begin
      saw_prog = 1;
      `CHK("vcc_first", OBPV_SUP_PROG, vcc)
    end
    `CHK("no_clash", 1'b0, d_oe & q_en)
  end
  // wait for the sequence to end, bounded
  task automatic wait_end();
    int n;
    n = 0;
    // let the request edge pass so a stale done is not taken
    @(negedge clk);
    while (done !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_end
  // pulses a cell gets: one first pass, then at most the retries
  function automatic int exp_pulses(input int need);
    return (need > 1 + RETRIES) ? 1 + RETRIES : need;
  endfunction : exp_pulses
  // program a fresh part whose slow cell needs a given pulse count
  task automatic run_prog(input int need);
    int expp;
    expp = exp_pulses(need);
    // never all ones, so an unprogrammed cell always mismatches
    foreach (img[i]) img[i] = 8'($random(seed)) & 8'hFE;
    foreach (pulses[i]) pulses[i] = 0;
    first = 1;
    saw_prog = 0;
    @(posedge clk);
    blank <= 1;
    weak_need <= 8'(need);
    weak_addr <= 2'($random(seed));
    start <= 1;
    @(posedge clk);
    start <= 0;
    blank <= 0;
    repeat (5) @(posedge clk);
    `CHK("busy", 1'b1, busy)
    start <= 1; // refused while busy
    @(posedge clk);
    start <= 0;
    wait_end();
    `CHK("done", 1'b1, done)
    `CHK("fail", need > 1 + RETRIES, fail)
    `CHK("prog_lvl", 1'b1, saw_prog)
    `CHK("vpp_low", OBPV_SUP_READ, vpp)
    `CHK("vcc_low", OBPV_SUP_READ, vcc)
    foreach (pulses[i]) begin
      if (i == weak_addr) `CHK("retries", expp, pulses[i])
      else `CHK("one_pulse", 1, pulses[i])
      if (need <= 1 + RETRIES) `CHK("stored", img[i], M.mem[i])
    end
    $display("test program need=%0d ended", need);
  endtask : run_prog
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    foreach (img[i]) img[i] = 8'h00;
    run_prog(1);
    run_prog(2);
    run_prog(11);
    run_prog(12);
    run_prog(1 + ({$random(seed)} % 11));
    @(posedge clk);
    id <= 1;
    @(posedge clk);
    id <= 0;
    wait_end();
    `CHK("maker", M.MAKER_ID, mk)
    `CHK("device", M.DEVICE_ID, dv)
    $display("test id read ended");
    conclude();
  end
endmodule : otp_byte_program_verify_tb_top
`default_nettype wire
